/* design/fsc_map.svh */
// Bit positions, reset values and divide counts for the fail-safe clock monitor
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH

// Internal RC divide ratio that forms the sample clock
`define FSC_SAMPLE_DIV 64
// Oscillator control register: clock select field and running flag
`define FSC_OSCCTL_SEL_LSB 0
`define FSC_OSCCTL_SEL_MSB 1
`define FSC_OSCCTL_RUN_BIT 3
`define FSC_OSCCTL_RESET 8'h00
// Peripheral interrupt flag register 2: oscillator fail flag
`define FSC_IRQ2_FAIL_BIT 7
`define FSC_IRQ2_RESET 8'h00

`endif

/* design/fsc_pkg.sv */
// Types shared by the fail-safe clock monitor
package fsc_pkg;

    // Clock select field codes
    typedef enum logic [1:0] {
        FSC_SRC_PRIMARY = 2'h0,
        FSC_SRC_SECONDARY = 2'h1,
        FSC_SRC_INTERNAL = 2'h2,
        FSC_SRC_INTERNAL_ALT = 2'h3
    } fsc_src_e;

    // Oscillator mode from the configuration fuses
    typedef enum logic [2:0] {
        FSC_MODE_LOW_POWER_CRYSTAL,
        FSC_MODE_STANDARD_CRYSTAL,
        FSC_MODE_HIGH_SPEED_CRYSTAL,
        FSC_MODE_CRYSTAL_PLL,
        FSC_MODE_EXTERNAL_CLOCK,
        FSC_MODE_EXTERNAL_RC,
        FSC_MODE_INTERNAL_RC
    } fsc_mode_e;

    // Controller states
    typedef enum logic [1:0] {
        FSC_ST_START,
        FSC_ST_RUN,
        FSC_ST_FAIL
    } fsc_state_e;

    // Whole state of the monitor
    typedef struct packed {
        fsc_state_e state;
        logic [1:0] dclk_sync;
        logic dclk_prev;
        logic [5:0] div_cnt;
        logic monitor_latch;
        logic fail_flag;
        logic pri_osc_en;
        logic running;
        fsc_src_e sel;
        fsc_src_e clk_mux;
        logic watchdog_clr;
        logic resume;
        logic pm_active;
    } fsc_state_s;

endpackage : fsc_pkg

/* design/fsc_monitor.sv */
// Fail-safe clock monitor with two-speed start-up control
`timescale 1ns/1ps
`include "fsc_map.svh"

module fsc_monitor #(
    parameter int DIV = `FSC_SAMPLE_DIV // Sample clock divide ratio
) (
    input wire logic clk_sys_i, // Internal RC oscillator clock
    input wire logic nrst_i, // Asynchronous reset, active low
    input wire logic monitor_enable_fuse_i, // Fail-safe monitor fuse
    input wire logic two_speed_enable_fuse_i, // Two-speed start-up fuse
    input wire fsc_pkg::fsc_mode_e osc_mode_i, // Primary oscillator mode
    input wire logic watchdog_enable_i, // Watchdog enabled
    input wire logic dev_clk_i, // Monitored device clock pin
    input wire logic osc_startup_timer_done_i, // Start-up and PLL timers expired
    input wire logic por_wake_i, // Pulse: POR or wake from Sleep
    input wire logic pm_enter_i, // Pulse: power-managed mode entry
    input wire logic idle_i, // Processor in Idle mode
    input wire logic irq_other_i, // Any other interrupt request
    input wire logic fail_irq_en_i, // Oscillator fail interrupt enable
    input wire logic sel_wr_i, // Write strobe for clock select field
    input wire fsc_pkg::fsc_src_e sel_wdata_i, // New clock select field
    input wire logic fail_clr_i, // Software clear of fail flag
    output logic [7:0] osc_control_reg_o, // Oscillator control register view
    output logic [7:0] periph_irq_flags2_o, // Interrupt flag register 2 view
    output fsc_pkg::fsc_src_e clk_mux_o, // Device clock source select
    output logic failsafe_o, // Fail-safe condition active
    output logic internal_rc_osc_en_o, // Internal RC oscillator enable
    output logic pri_osc_en_o, // Primary oscillator enable
    output logic watchdog_clear_o, // Pulse: clear watchdog and postscaler
    output logic cpu_resume_o // Pulse: resume execution on internal clock
);

    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] RISE_CNT = CW'(DIV / 2 - 1); // Sample clock rises after
    localparam logic [CW-1:0] FALL_CNT = CW'(DIV - 1); // Sample clock falls after

    fsc_pkg::fsc_state_s st_r; // Registered state
    fsc_pkg::fsc_state_s st_nxt; // Next state

    logic crystal_mode; // Primary needs start-up timer
    logic dclk_fall; // Synchronised falling edge of device clock
    logic sample_rise; // Sample clock rising edge
    logic sample_fall; // Sample clock falling edge
    logic mon_active; // Monitoring armed for the current source
    logic fail_det; // Clock failure detected this cycle

    // Decode of crystal or resonator oscillator modes
    always_comb begin
        crystal_mode = (osc_mode_i == fsc_pkg::FSC_MODE_LOW_POWER_CRYSTAL) ||
                       (osc_mode_i == fsc_pkg::FSC_MODE_STANDARD_CRYSTAL) ||
                       (osc_mode_i == fsc_pkg::FSC_MODE_HIGH_SPEED_CRYSTAL) ||
                       (osc_mode_i == fsc_pkg::FSC_MODE_CRYSTAL_PLL);
    end

    // Edge and failure terms
    always_comb begin
        dclk_fall = st_r.dclk_prev & ~st_r.dclk_sync[1];
        sample_rise = (st_r.div_cnt[CW-1:0] == RISE_CNT);
        sample_fall = (st_r.div_cnt[CW-1:0] == FALL_CNT);
        // Only primary and secondary sources are watched
        mon_active = monitor_enable_fuse_i &&
                     (st_r.state == fsc_pkg::FSC_ST_RUN) &&
                     (st_r.clk_mux == fsc_pkg::FSC_SRC_PRIMARY ||
                      st_r.clk_mux == fsc_pkg::FSC_SRC_SECONDARY);
        fail_det = mon_active && sample_fall && st_r.monitor_latch;
    end

    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.watchdog_clr = 1'b0;
        st_nxt.resume = 1'b0;
        // Two-flop synchroniser, only the second flop is looked at
        st_nxt.dclk_sync = {st_r.dclk_sync[0], dev_clk_i};
        st_nxt.dclk_prev = st_r.dclk_sync[1];
        // Free-running divider of the internal RC clock
        st_nxt.div_cnt = (st_r.div_cnt == FALL_CNT) ? '0 : st_r.div_cnt + 6'h01;
        // Latch: sample rise clears, device clock fall sets and wins
        if (dclk_fall) begin
            st_nxt.monitor_latch = 1'b1;
        end else if (sample_rise) begin
            st_nxt.monitor_latch = 1'b0;
        end
        // Clock select field is writable in every state
        if (sel_wr_i) begin
            st_nxt.sel = sel_wdata_i;
        end
        // Fail flag: hardware set wins over software clear
        if (fail_det) begin
            st_nxt.fail_flag = 1'b1;
        end else if (fail_clr_i) begin
            st_nxt.fail_flag = 1'b0;
        end
        // POR or wake from Sleep restarts the primary clock
        if (por_wake_i) begin
            st_nxt.pri_osc_en = 1'b1;
            st_nxt.pm_active = 1'b0;
            if (crystal_mode) begin
                // Run internally until the timers expire
                st_nxt.state = fsc_pkg::FSC_ST_START;
                st_nxt.clk_mux = fsc_pkg::FSC_SRC_INTERNAL;
                st_nxt.running = 1'b0;
            end else begin
                // No start-up delay, watch at once
                st_nxt.state = fsc_pkg::FSC_ST_RUN;
                st_nxt.clk_mux = fsc_pkg::FSC_SRC_PRIMARY;
                st_nxt.running = 1'b1;
            end
        end else begin
            case (st_r.state)
                // Waiting for primary; no failure is flagged here
                fsc_pkg::FSC_ST_START: begin
                    if (pm_enter_i) begin
                        // Another mode chosen: switch to its source, primary off unless selected
                        st_nxt.state = fsc_pkg::FSC_ST_RUN;
                        st_nxt.pm_active = 1'b1;
                        st_nxt.clk_mux = st_r.sel;
                        if (st_r.sel != fsc_pkg::FSC_SRC_PRIMARY) begin
                            st_nxt.pri_osc_en = 1'b0;
                        end
                    end else if (osc_startup_timer_done_i) begin
                        st_nxt.state = fsc_pkg::FSC_ST_RUN;
                        st_nxt.clk_mux = fsc_pkg::FSC_SRC_PRIMARY;
                        st_nxt.running = 1'b1;
                    end
                    // Else stay on internal clock indefinitely
                end
                // Clocked by the selected source, monitored only on primary or secondary
                fsc_pkg::FSC_ST_RUN: begin
                    if (fail_det) begin
                        // Control register is left as it was
                        st_nxt.state = fsc_pkg::FSC_ST_FAIL;
                        st_nxt.clk_mux = fsc_pkg::FSC_SRC_INTERNAL;
                        st_nxt.watchdog_clr = 1'b1;
                    end else if (pm_enter_i) begin
                        st_nxt.pm_active = 1'b1;
                        st_nxt.clk_mux = st_r.sel;
                    end
                end
                // Fail-safe: internal clock until reset or mode entry
                fsc_pkg::FSC_ST_FAIL: begin
                    if (pm_enter_i) begin
                        st_nxt.state = fsc_pkg::FSC_ST_RUN;
                        st_nxt.pm_active = 1'b1;
                        st_nxt.clk_mux = st_r.sel;
                    end else if (st_r.pm_active && !fail_irq_en_i && idle_i &&
                                 irq_other_i) begin
                        st_nxt.resume = 1'b1;
                    end
                    // No automatic return to the failed source
                end
                default: begin
                    st_nxt.state = fsc_pkg::FSC_ST_START;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '{state: fsc_pkg::FSC_ST_START, dclk_sync: 2'h0, dclk_prev: 1'b0,
                      div_cnt: 6'h00, monitor_latch: 1'b0, fail_flag: 1'b0,
                      pri_osc_en: 1'b1, running: 1'b0, sel: fsc_pkg::FSC_SRC_PRIMARY,
                      clk_mux: fsc_pkg::FSC_SRC_INTERNAL, watchdog_clr: 1'b0, resume: 1'b0,
                      pm_active: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Register views and control outputs
    always_comb begin
        osc_control_reg_o = `FSC_OSCCTL_RESET;
        osc_control_reg_o[`FSC_OSCCTL_SEL_MSB:`FSC_OSCCTL_SEL_LSB] = st_r.sel;
        osc_control_reg_o[`FSC_OSCCTL_RUN_BIT] = st_r.running;
        periph_irq_flags2_o = `FSC_IRQ2_RESET;
        periph_irq_flags2_o[`FSC_IRQ2_FAIL_BIT] = st_r.fail_flag;
        clk_mux_o = st_r.clk_mux;
        failsafe_o = (st_r.state == fsc_pkg::FSC_ST_FAIL);
        // RC stays on for the monitor regardless of the watchdog
        internal_rc_osc_en_o = monitor_enable_fuse_i | watchdog_enable_i |
                               two_speed_enable_fuse_i |
                               (st_r.clk_mux != fsc_pkg::FSC_SRC_PRIMARY &&
                                st_r.clk_mux != fsc_pkg::FSC_SRC_SECONDARY);
        pri_osc_en_o = st_r.pri_osc_en;
        watchdog_clear_o = st_r.watchdog_clr;
        cpu_resume_o = st_r.resume;
    end

    // Latch goes high the cycle after a synchronised device clock fall
    a_latch_set: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $fell(st_r.dclk_sync[1]) |=> st_r.monitor_latch)
        else $error("monitor latch not set after device clock fall");

    // Sample rise with no device edge clears the latch
    a_latch_clear: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (sample_rise && !dclk_fall) |=> !st_r.monitor_latch)
        else $error("monitor latch not cleared by sample rise");

    // Failure moves to fail-safe with flag, internal clock, watchdog clear
    a_fail_action: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (fail_det && !por_wake_i) |=> (failsafe_o && periph_irq_flags2_o[7]
            && watchdog_clear_o && clk_mux_o == fsc_pkg::FSC_SRC_INTERNAL))
        else $error("failure did not trigger fail-safe actions");

    // Watchdog clear lasts exactly one cycle
    a_watchdog_pulse: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        watchdog_clear_o |=> !watchdog_clear_o)
        else $error("watchdog clear longer than one cycle");

    // Control register is untouched by a failure
    a_ctrl_stable: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (fail_det && !sel_wr_i && !por_wake_i) |=> $stable(osc_control_reg_o))
        else $error("control register changed on failure");

    // Fail-safe holds unless reset or power-managed entry
    a_fail_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (failsafe_o && !pm_enter_i && !por_wake_i) |=> failsafe_o)
        else $error("fail-safe left without exit event");

    // No failure flagged while waiting on start-up
    a_start_noflag: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (st_r.state == fsc_pkg::FSC_ST_START && !fail_clr_i) |=> $stable(st_r.fail_flag))
        else $error("fail flag changed during start-up");

    // Timer expiry sets running flag on the next cycle
    a_timer_switch: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (st_r.state == fsc_pkg::FSC_ST_START && osc_startup_timer_done_i && !pm_enter_i
            && !por_wake_i) |=> (osc_control_reg_o[3] && clk_mux_o == fsc_pkg::FSC_SRC_PRIMARY))
        else $error("no switch to primary after timer expiry");

    // Internal source is never declared failed
    a_int_nomon: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (st_r.clk_mux == fsc_pkg::FSC_SRC_INTERNAL) |-> !fail_det)
        else $error("failure detected on internal source");

    // RC oscillator stays on whenever the monitor fuse is set
    a_rc_on: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        monitor_enable_fuse_i |-> internal_rc_osc_en_o)
        else $error("internal RC stopped while monitoring");

    // Leaving start-up for a mode on a non-primary source turns the primary off
    a_pri_off: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (st_r.state == fsc_pkg::FSC_ST_START && pm_enter_i && !por_wake_i
            && st_r.sel != fsc_pkg::FSC_SRC_PRIMARY) |=> !pri_osc_en_o)
        else $error("primary left on after mode change");

    // A select write shows in the control register on the next cycle
    a_sel_write: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        sel_wr_i |=> (osc_control_reg_o[1:0] == $past(sel_wdata_i)))
        else $error("clock select write not taken");

    // Divider wraps to zero after its last count
    a_div_wrap: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (st_r.div_cnt == FALL_CNT) |=> (st_r.div_cnt == 6'h00))
        else $error("sample divider did not wrap");

    // Divider otherwise advances by one every cycle
    a_div_step: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (st_r.div_cnt != FALL_CNT) |=> (st_r.div_cnt == $past(st_r.div_cnt) + 6'h01))
        else $error("sample divider skipped a count");

    // Device clock fall wins over a sample rise in the same cycle
    a_latch_wins: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (dclk_fall && sample_rise) |=> st_r.monitor_latch)
        else $error("monitor latch lost a device clock fall");

    // A failure beats a software clear of the fail flag
    a_flag_win: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (fail_det && fail_clr_i) |=> periph_irq_flags2_o[7])
        else $error("fail flag lost to software clear");

    // Software clear with no failure drops the flag
    a_flag_clear: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (fail_clr_i && !fail_det) |=> !periph_irq_flags2_o[7])
        else $error("fail flag not cleared");

    // Start-up event always turns the primary oscillator on
    a_pri_on: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        por_wake_i |=> pri_osc_en_o)
        else $error("primary not enabled after start-up event");

    // Crystal modes start on the internal clock with the flag low
    a_por_crystal: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (por_wake_i && crystal_mode) |=> (clk_mux_o == fsc_pkg::FSC_SRC_INTERNAL
            && !osc_control_reg_o[3] && !failsafe_o))
        else $error("crystal start-up not on internal clock");

    // Other modes run from primary and are watched at once
    a_por_direct: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (por_wake_i && !crystal_mode) |=> (clk_mux_o == fsc_pkg::FSC_SRC_PRIMARY
            && osc_control_reg_o[3]))
        else $error("direct start-up not on primary clock");

    // Mode entry selects the source held in the control register
    a_pm_select: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (pm_enter_i && !por_wake_i && !fail_det) |=> (clk_mux_o == $past(st_r.sel)))
        else $error("mode entry chose wrong source");

    // Fail-safe keeps the internal clock until an exit event
    a_fail_stay: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (failsafe_o && !pm_enter_i && !por_wake_i) |=> clk_mux_o == fsc_pkg::FSC_SRC_INTERNAL)
        else $error("fail-safe returned to failed source");

    // Idle interrupt with the fail interrupt off resumes the core
    a_resume_go: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (failsafe_o && st_r.pm_active && !fail_irq_en_i && idle_i && irq_other_i
            && !pm_enter_i && !por_wake_i) |=> cpu_resume_o)
        else $error("no resume after idle interrupt");

    // Resume never pulses outside fail-safe
    a_resume_only: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !failsafe_o |=> !cpu_resume_o)
        else $error("resume pulse outside fail-safe");

endmodule : fsc_monitor

/* verif/fsc_clk_src.sv */
// Model of the external oscillator that feeds the monitored device clock
`timescale 1ns/1ps

module fsc_clk_src #(
    parameter int HALF_NS = 12 // Half period, longer than one system cycle
) (
    input wire logic run_i, // Oscillator running
    output logic clk_o // Device clock pin
);
    // A stopped oscillator leaves its pin low, as a dead crystal does
    // Offset by 1 ns so that no pin edge meets a system clock edge
    initial begin
        clk_o = 1'b0;
        #1;
        forever begin
            #(HALF_NS);
            if (run_i) begin
                clk_o = ~clk_o;
            end else begin
                clk_o = 1'b0;
            end
        end
    end
endmodule : fsc_clk_src

/* verif/fsc_monitor_bench.sv */
// Self-checking bench for the fail-safe clock monitor
`timescale 1ns/1ps

module fsc_monitor_bench;
    localparam int DIV = 8; // Short sample period keeps the run brief
    logic clk_sys_i = 1'b0, nrst_i = 1'b0, mon_fuse = 1'b1, ts_fuse = 1'b0, dog_en = 1'b0;
    logic dev_clk, src_run = 1'b0, tmr_done = 1'b0, por_wake = 1'b0, pm_enter = 1'b0;
    logic idle = 1'b0, irq_other = 1'b0, irq_en = 1'b1, sel_wr = 1'b0, fail_clr = 1'b0;
    fsc_pkg::fsc_mode_e mode = fsc_pkg::FSC_MODE_HIGH_SPEED_CRYSTAL; // Crystal mode first
    fsc_pkg::fsc_src_e sel_wdata = fsc_pkg::FSC_SRC_PRIMARY;
    logic [7:0] ctl_o, flg_o;
    fsc_pkg::fsc_src_e mux_o;
    logic fs_o, rc_en_o, pri_en_o, dog_clr_o, resume_o;
    int err_count = 0, comparisons = 0;
    logic [31:0] seed = 32'hbc0e4f04;
    // Reference model state
    logic [1:0] e_sel = 2'h0, e_mux = 2'h2;
    logic e_run = 1'b0, e_flag = 1'b0, e_fs = 1'b0;

    // System clock, 8 ns period
    always begin
        #4 clk_sys_i = ~clk_sys_i;
    end

    fsc_clk_src src (.run_i(src_run), .clk_o(dev_clk));

    fsc_monitor #(.DIV(DIV)) dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .monitor_enable_fuse_i(mon_fuse), .two_speed_enable_fuse_i(ts_fuse),
        .osc_mode_i(mode), .watchdog_enable_i(dog_en), .dev_clk_i(dev_clk),
        .osc_startup_timer_done_i(tmr_done), .por_wake_i(por_wake), .pm_enter_i(pm_enter),
        .idle_i(idle), .irq_other_i(irq_other), .fail_irq_en_i(irq_en), .sel_wr_i(sel_wr),
        .sel_wdata_i(sel_wdata), .fail_clr_i(fail_clr), .osc_control_reg_o(ctl_o),
        .periph_irq_flags2_o(flg_o), .clk_mux_o(mux_o), .failsafe_o(fs_o),
        .internal_rc_osc_en_o(rc_en_o), .pri_osc_en_o(pri_en_o), .watchdog_clear_o(dog_clr_o),
        .cpu_resume_o(resume_o));

    // Next value of the stimulus shift register
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    // Compare one observed byte with its expected value
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Compare the control and flag registers, clock select and fail-safe output against the model
    task automatic check_all();
        chk(ctl_o, {4'h0, e_run, 1'b0, e_sel});
        chk(flg_o, {e_flag, 7'h00});
        chk({6'h00, mux_o}, {6'h00, e_mux});
        chk({7'h00, fs_o}, {7'h00, e_fs});
    endtask : check_all

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : cyc

    // Write the clock select field through its strobe
    task automatic wr_sel(input logic [1:0] v);
        @(negedge clk_sys_i);
        sel_wr = 1'b1;
        sel_wdata = fsc_pkg::fsc_src_e'(v);
        @(negedge clk_sys_i);
        sel_wr = 1'b0;
        e_sel = v;
    endtask : wr_sel

    // Wait a bounded time for the switch to the backup clock, then check it
    task automatic wait_fail();
        int n;
        n = 0;
        while (fs_o !== 1'b1 && n < 2 * DIV + 24) begin
            cyc(1);
            n++;
        end
        chk({7'h00, dog_clr_o}, 8'h01);
        e_fs = 1'b1;
        e_mux = 2'h2;
        e_flag = 1'b1;
        check_all();
        cyc(1);
        chk({7'h00, dog_clr_o}, 8'h00);
    endtask : wait_fail

    // Stop the source, let the latch drain, then clear the sticky flag
    task automatic quiet();
        src_run = 1'b0;
        cyc(2 * DIV);
        fail_clr = 1'b1;
        cyc(1);
        fail_clr = 1'b0;
        cyc(1);
        e_flag = 1'b0;
    endtask : quiet

    // Print the counts and the verdict, then end the run
    task automatic summarize();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    // Cut a hang short
    initial begin
        #200us;
        err_count++;
        summarize();
    end

    // Main sequence
    initial begin
        cyc(20);
        nrst_i = 1'b1;
        cyc(1);
        check_all();
        chk({6'h00, pri_en_o, rc_en_o}, 8'h03);
        por_wake = 1'b1;
        src_run = 1'b1;
        cyc(1);
        por_wake = 1'b0;
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            irq_other = seed[4];
            wr_sel(seed[1:0]);
            check_all();
        end
        wr_sel(2'h0);
        tmr_done = 1'b1;
        cyc(1);
        e_run = 1'b1;
        e_mux = 2'h0;
        check_all();
        wait_fail();
        tmr_done = 1'b0;
        cyc(4 * DIV);
        check_all();
        quiet();
        pm_enter = 1'b1;
        cyc(1);
        pm_enter = 1'b0;
        e_fs = 1'b0;
        e_mux = 2'h0;
        check_all();
        src_run = 1'b1;
        wait_fail();
        cyc(4 * DIV);
        check_all();
        irq_en = 1'b0;
        idle = 1'b1;
        irq_other = 1'b1;
        cyc(1);
        chk({7'h00, resume_o}, 8'h01);
        idle = 1'b0;
        irq_en = 1'b1;
        quiet();
        wr_sel(2'h2);
        pm_enter = 1'b1;
        cyc(1);
        pm_enter = 1'b0;
        e_fs = 1'b0;
        src_run = 1'b1;
        cyc(4 * DIV);
        check_all();
        quiet();
        wr_sel(2'h0);
        mode = fsc_pkg::FSC_MODE_EXTERNAL_CLOCK;
        por_wake = 1'b1;
        cyc(1);
        por_wake = 1'b0;
        e_mux = 2'h0;
        check_all();
        chk({7'h00, rc_en_o}, 8'h01);
        src_run = 1'b1;
        wait_fail();
        quiet();
        mode = fsc_pkg::FSC_MODE_HIGH_SPEED_CRYSTAL;
        por_wake = 1'b1;
        cyc(1);
        por_wake = 1'b0;
        e_fs = 1'b0;
        e_run = 1'b0;
        check_all();
        wr_sel(2'h1);
        pm_enter = 1'b1;
        cyc(1);
        pm_enter = 1'b0;
        e_mux = 2'h1;
        check_all();
        chk({7'h00, pri_en_o}, 8'h00);
        summarize();
    end
endmodule : fsc_monitor_bench
